/* ued_buffers.sv */
// Endpoint data buffers: setup capture, control IN FIFO, bulk-out ping-pong banks.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`include "ued_defines.svh"

module ued_buffers
    import ued_pkg::*;
(
    // Clock and reset.
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    // Avalon-MM register slave, word addressed.
    input  wire logic [15:0]   avsAddress,
    input  wire logic          avsRead,
    input  wire logic          avsWrite,
    input  wire logic [3:0]    avsByteEnable,
    input  wire logic [31:0]   avsWriteData,
    output logic [31:0]        avsReadData,
    output logic               avsWaitRequest,
    // Serial engine side.
    input  wire logic          sieBusReset,
    input  wire ued_setup_rx_t setupRx,
    input  wire ued_in_ctl_t   inCtl,
    input  wire ued_out_rx_t   outRx,
    output ued_tx_t            inTx,
    // Endpoint status to the controller.
    output logic               bulkOutStall,
    output logic               endpointEventIrq
);

    // ------------------------------------------------------------------------
    // Constants and decode
    // ------------------------------------------------------------------------

    // Reset image of the whole state; the bus slave idles with waitrequest high.
    localparam ued_state_t StReset = '{waitReq: 1'b1, txState: TX_IDLE, default: '0};
    localparam logic [3:0] SetupFull = 4'(`UED_SETUP_BYTES);
    localparam logic [6:0] FifoFull  = 7'(`UED_FIFO_BYTES);

    // Compares the bus word address with a register index.
    function automatic logic regHit(input logic [15:0] addr, input logic [15:0] idx);
        regHit = (addr == idx);
    endfunction

    ued_state_t st_q;
    ued_state_t st_d;
    logic       accRd;
    logic       accWr;

    // An access is served in the cycle where waitrequest is still high.
    assign accRd = avsRead && st_q.waitReq;
    assign accWr = avsWrite && st_q.waitReq && avsByteEnable[0];

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------

    // Bus access first, then engine events, so hardware sets win over clears.
    always_comb begin
        st_d         = st_q;
        st_d.tx      = '0;
        st_d.irq     = 1'b0;
        st_d.waitReq = !((avsRead || avsWrite) && st_q.waitReq);

        // Register reads with their side effects.
        if (accRd) begin
            st_d.rdData = '0;
            if (regHit(avsAddress, `UED_IDX_SETUP_CAPTURE)) begin
                st_d.rdData[7:0] = st_q.setupCap[st_q.setupRdPtr];
                st_d.setupRdPtr  = st_q.setupRdPtr + 3'h1;
            end else if (regHit(avsAddress, `UED_IDX_BULK_OUT_DATA)) begin
                // An empty count pins the offset so the first byte repeats.
                st_d.rdData[7:0] = st_q.boMem[~st_q.sieBank][(st_q.boLen != 7'h00) ?
                                   st_q.boRdOff : 6'h00];
                if (st_q.boLen != 7'h00) begin
                    st_d.boRdOff = st_q.boRdOff + 6'h01;
                    st_d.boLen   = st_q.boLen - 7'h01;
                end
            end else if (regHit(avsAddress, `UED_IDX_BULK_OUT_LENGTH)) begin
                st_d.rdData[6:0] = st_q.boLen;
            end else if (regHit(avsAddress, `UED_IDX_STATUS)) begin
                st_d.rdData[`UED_ST_SETUP_PROTECT_FLAG]   = st_q.protFlag;
                st_d.rdData[`UED_ST_FWDEC]  = st_q.fwDecodeFlag;
                st_d.rdData[`UED_ST_BODATA] = st_q.bulkOutDataFlag;
                st_d.rdData[`UED_ST_INDATA] = (st_q.inCnt != 7'h00);
            end else if (regHit(avsAddress, `UED_IDX_CONTROL)) begin
                st_d.rdData[`UED_CT_INRDY] = st_q.ctlInReady;
                st_d.rdData[`UED_CT_DEND]  = st_q.ctlDataEnd;
                st_d.rdData[`UED_CT_BORDY] = st_q.bulkOutReady;
                st_d.rdData[`UED_CT_STALL] = st_q.stall;
            end else if (regHit(avsAddress, `UED_IDX_CTL_IN_WRITE)) begin
                st_d.rdData[7:0] = `UED_IN_READ_VALUE;
            end
        end

        // Register writes; the capture and bulk-out data registers ignore them.
        if (accWr) begin
            if (regHit(avsAddress, `UED_IDX_CTL_IN_WRITE) && st_q.inCnt != FifoFull) begin
                st_d.inMem[st_q.inCnt[5:0]] = avsWriteData[7:0];
                st_d.inCnt = st_q.inCnt + 7'h01;
            end
            if (regHit(avsAddress, `UED_IDX_STATUS)) begin
                if (avsWriteData[`UED_ST_SETUP_PROTECT_FLAG]) begin
                    st_d.protFlag = 1'b0;
                end
                if (avsWriteData[`UED_ST_FWDEC]) begin
                    st_d.fwDecodeFlag = 1'b0;
                end
                if (avsWriteData[`UED_ST_BODATA]) begin
                    st_d.bulkOutDataFlag = 1'b0;
                end
            end
            if (regHit(avsAddress, `UED_IDX_CONTROL)) begin
                st_d.ctlInReady   = avsWriteData[`UED_CT_INRDY];
                st_d.ctlDataEnd   = avsWriteData[`UED_CT_DEND];
                st_d.bulkOutReady = avsWriteData[`UED_CT_BORDY];
                if (avsWriteData[`UED_CT_STALL]) begin
                    st_d.stall = 1'b0;
                end
            end
        end

        // SETUP bytes gather in a stage and commit only at a full-length end.
        if (setupRx.token) begin
            st_d.setupRxCnt = 4'h0;
        end
        if (setupRx.valid && st_q.setupRxCnt < SetupFull) begin
            st_d.setupStage[st_q.setupRxCnt[2:0]] = setupRx.data;
            st_d.setupRxCnt = st_q.setupRxCnt + 4'h1;
        end
        if (setupRx.done && st_q.setupRxCnt == SetupFull) begin
            if (setupRx.ok) begin
                st_d.setupCap = st_q.setupStage;
                st_d.protFlag = 1'b1;
                if (setupRx.fwReq) begin
                    st_d.fwDecodeFlag = 1'b1;
                end
                st_d.irq = 1'b1;
            end else begin
                st_d.setupCap = {`UED_SETUP_BYTES{`UED_SETUP_RESET}};
            end
        end

        // Control IN sequencer: answer tokens, stream bytes, wait for ACK.
        unique case (st_q.txState)
            TX_IDLE, TX_WAIT: begin
                if (inCtl.token) begin
                    if (st_q.ctlInReady && st_q.inCnt != 7'h00) begin
                        st_d.txState   = TX_SEND;
                        st_d.inSendIdx = 6'h00;
                    end else if (st_q.ctlInReady && st_q.ctlDataEnd) begin
                        st_d.tx.zlp  = 1'b1;
                        st_d.txState = TX_WAIT;
                    end else begin
                        st_d.tx.nak = 1'b1;
                    end
                end else if (st_q.txState == TX_WAIT && inCtl.ack) begin
                    st_d.ctlInReady = 1'b0;
                    st_d.ctlDataEnd = 1'b0;
                    st_d.inCnt      = 7'h00;
                    st_d.txState    = TX_IDLE;
                end
            end
            TX_SEND: begin
                st_d.tx.valid  = 1'b1;
                st_d.tx.data   = st_q.inMem[st_q.inSendIdx];
                st_d.tx.last   = ({1'b0, st_q.inSendIdx} + 7'h01 == st_q.inCnt);
                st_d.inSendIdx = st_q.inSendIdx + 6'h01;
                if (st_d.tx.last) begin
                    st_d.txState = TX_WAIT;
                end
            end
            default: begin
                st_d.txState = TX_IDLE;
            end
        endcase

        // Status stage reached without ACK drops a pending transfer and its queued bytes.
        if (inCtl.statusStage && (st_q.txState != TX_IDLE || st_q.ctlInReady)) begin
            st_d.inCnt      = 7'h00;
            st_d.ctlInReady = 1'b0;
            st_d.ctlDataEnd = 1'b0;
            st_d.txState    = TX_IDLE;
        end

        // A fresh SETUP token cancels a pending control IN transfer.
        if (setupRx.token && (st_q.txState != TX_IDLE || st_q.ctlInReady)) begin
            st_d.inCnt      = 7'h00;
            st_d.ctlInReady = 1'b0;
            st_d.ctlDataEnd = 1'b0;
            st_d.txState    = TX_IDLE;
        end

        // Bulk-out bytes fill the engine-side bank; overrun stalls the endpoint.
        if (outRx.valid) begin
            if (st_q.sieFull) begin
                if (st_q.boLen != 7'h00) begin
                    st_d.stall = 1'b1;
                    st_d.boLen = 7'h00;
                end
            end else if (st_q.sieCnt != FifoFull) begin
                st_d.boMem[st_q.sieBank][st_q.sieCnt[5:0]] = outRx.data;
                st_d.sieCnt = st_q.sieCnt + 7'h01;
            end
        end
        if (outRx.done && !st_q.sieFull) begin
            if (outRx.ok) begin
                st_d.sieFull = 1'b1;
            end else begin
                st_d.sieCnt = 7'h00;
                if (st_q.boLen == 7'h00) begin
                    st_d.boLen = 7'h00;
                end
            end
        end

        // Bus reset clears the transfer state; the setup read pointer survives.
        if (sieBusReset) begin
            st_d.inCnt      = 7'h00;
            st_d.ctlInReady = 1'b0;
            st_d.ctlDataEnd = 1'b0;
            st_d.txState    = TX_IDLE;
            st_d.sieCnt     = 7'h00;
            st_d.sieFull    = 1'b0;
        end

        // Bank swap once the engine bank is complete and the CPU bank drained.
        if (st_d.sieFull && st_d.boLen == 7'h00) begin
            st_d.sieBank         = ~st_d.sieBank;
            st_d.boLen           = st_d.sieCnt;
            st_d.boRdOff         = 6'h00;
            st_d.sieCnt          = 7'h00;
            st_d.sieFull         = 1'b0;
            st_d.bulkOutDataFlag = 1'b1;
            st_d.irq             = 1'b1;
            st_d.bulkOutReady    = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // State register and outputs
    // ------------------------------------------------------------------------

    // Registers the whole state image.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= StReset;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state register.
    assign avsReadData      = st_q.rdData;
    assign avsWaitRequest   = st_q.waitReq;
    assign inTx             = st_q.tx;
    assign bulkOutStall     = st_q.stall;
    assign endpointEventIrq = st_q.irq;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic setupGood;
    logic boRead;
    assign setupGood = setupRx.done && setupRx.ok && st_q.setupRxCnt == SetupFull;
    assign boRead    = accRd && regHit(avsAddress, `UED_IDX_BULK_OUT_DATA);

    a_setup_rd_advance: assert property (
        accRd && regHit(avsAddress, `UED_IDX_SETUP_CAPTURE)
        |=> st_q.setupRdPtr == $past(st_q.setupRdPtr) + 3'h1 && !avsWaitRequest)
        else $error("setup read pointer did not advance");
    a_setup_good_flags: assert property (
        setupGood |=> st_q.protFlag && endpointEventIrq ##1 !endpointEventIrq)
        else $error("good setup did not flag and pulse interrupt");
    a_setup_bad_drop: assert property (
        setupRx.done && !setupRx.ok && st_q.setupRxCnt == SetupFull && !st_q.sieFull
        |=> !endpointEventIrq && st_q.setupCap == '0)
        else $error("bad setup kept data or raised interrupt");
    a_setup_short_keep: assert property (
        setupRx.done && st_q.setupRxCnt < SetupFull |=> $stable(st_q.setupCap))
        else $error("short setup changed capture");
    a_in_nak_answer: assert property (
        inCtl.token && !st_q.ctlInReady && st_q.txState != TX_SEND
        |=> inTx.nak && !inTx.valid)
        else $error("token without ready not answered by NAK");
    a_in_ack_clear: assert property (
        st_q.txState == TX_WAIT && inCtl.ack && !inCtl.token && !accWr
        |=> !st_q.ctlInReady && st_q.inCnt == 7'h00)
        else $error("ready bit not cleared after ACK");
    a_in_read_zero: assert property (
        accRd && regHit(avsAddress, `UED_IDX_CTL_IN_WRITE) |=> avsReadData == 32'h0)
        else $error("IN FIFO read did not return zero");
    a_bo_len_dec: assert property (
        boRead && st_q.boLen > 7'h01 && !outRx.valid
        |=> st_q.boLen == $past(st_q.boLen) - 7'h01)
        else $error("length not decremented on bulk read");
    a_bo_swap: assert property (
        outRx.done && outRx.ok && !st_q.sieFull && st_q.boLen == 7'h00 && !sieBusReset
        |=> st_q.sieBank != $past(st_q.sieBank) && st_q.bulkOutDataFlag && endpointEventIrq)
        else $error("bank swap did not occur");
    a_in_status_flush: assert property (
        inCtl.statusStage && st_q.txState == TX_WAIT |=> st_q.inCnt == 7'h00)
        else $error("status stage did not empty IN FIFO");

    c_setup_good: cover property (setupGood ##1 endpointEventIrq);
    c_in_zlp: cover property (inTx.zlp);
    c_in_packet: cover property (inTx.valid && inTx.last);
    c_bo_swap: cover property (st_q.bulkOutDataFlag && st_q.boLen != 7'h00);
    c_bo_stall: cover property (bulkOutStall);

endmodule

/* ued_defines.svh */
// Constants for the endpoint data buffers: register indices, bit positions, sizes.
`ifndef UED_DEFINES_SVH
`define UED_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------------
`define UED_IDX_BULK_OUT_DATA   16'hff0d
`define UED_IDX_SETUP_CAPTURE   16'hff18
`define UED_IDX_CTL_IN_WRITE    16'hff19
`define UED_IDX_STATUS          16'hff20
`define UED_IDX_CONTROL         16'hff21
`define UED_IDX_BULK_OUT_LENGTH 16'hff77

// ----------------------------------------------------------------------------
// Sizes and values
// ----------------------------------------------------------------------------
`define UED_SETUP_BYTES   8
`define UED_FIFO_BYTES    64
`define UED_SETUP_RESET   8'h00
`define UED_IN_READ_VALUE 8'h00

// ----------------------------------------------------------------------------
// Status register bits (write one to clear the sticky ones)
// ----------------------------------------------------------------------------
`define UED_ST_SETUP_PROTECT_FLAG   0
`define UED_ST_FWDEC  1
`define UED_ST_BODATA 2
`define UED_ST_INDATA 4

// ----------------------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------------------
`define UED_CT_INRDY 0
`define UED_CT_DEND  1
`define UED_CT_BORDY 2
`define UED_CT_STALL 3

`endif

/* ued_pkg.sv */
// Types shared by the endpoint data buffers.
package ued_pkg;
`include "ued_defines.svh"

    // Control IN transmit sequencer states.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_WAIT = 2'b10
    } ued_tx_state_t;

    // SETUP stage bytes from the serial engine.
    typedef struct packed {
        logic       token;
        logic       valid;
        logic [7:0] data;
        logic       done;
        logic       ok;
        logic       fwReq;
    } ued_setup_rx_t;

    // Control IN token events from the serial engine.
    typedef struct packed {
        logic token;
        logic ack;
        logic statusStage;
    } ued_in_ctl_t;

    // Bulk-out data bytes from the serial engine.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       done;
        logic       ok;
    } ued_out_rx_t;

    // Control IN answer to the serial engine.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       zlp;
        logic       nak;
    } ued_tx_t;

    // Whole state of the buffer block.
    typedef struct packed {
        logic [`UED_SETUP_BYTES-1:0][7:0]      setupStage;
        logic [`UED_SETUP_BYTES-1:0][7:0]      setupCap;
        logic [3:0]                            setupRxCnt;
        logic [2:0]                            setupRdPtr;
        logic                                  protFlag;
        logic                                  fwDecodeFlag;
        logic                                  bulkOutDataFlag;
        logic                                  ctlInReady;
        logic                                  ctlDataEnd;
        logic                                  bulkOutReady;
        logic                                  stall;
        logic [`UED_FIFO_BYTES-1:0][7:0]       inMem;
        logic [6:0]                            inCnt;
        logic [5:0]                            inSendIdx;
        ued_tx_state_t                         txState;
        logic [1:0][`UED_FIFO_BYTES-1:0][7:0]  boMem;
        logic                                  sieBank;
        logic [6:0]                            sieCnt;
        logic                                  sieFull;
        logic [6:0]                            boLen;
        logic [5:0]                            boRdOff;
        ued_tx_t                               tx;
        logic                                  irq;
        logic                                  waitReq;
        logic [31:0]                           rdData;
    } ued_state_t;

endpackage

/* ued_sie_model.sv */
// Serial engine model that plays the host side of the endpoint buffers.
`timescale 1ns/10ps
module ued_sie_model
    import ued_pkg::*;
(
    // Clock.
    input  wire logic     ref_clk,
    // Engine traffic towards the buffers.
    output ued_setup_rx_t setupRx,
    output ued_in_ctl_t   inCtl,
    output ued_out_rx_t   outRx
);
    // All lines idle at time zero.
    initial begin
        setupRx = '0;
        inCtl   = '0;
        outRx   = '0;
    end

    // Sends a token, n setup bytes counting up from base, then the end of transaction.
    task automatic setup(input int n, input logic ok, input logic fw, input logic [7:0] base);
        @(posedge ref_clk) setupRx.token <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) setupRx.token <= 1'b0;
            setupRx.valid <= 1'b1;
            setupRx.data  <= base + 8'(i);
        end
        @(posedge ref_clk) setupRx.valid <= 1'b0;
        setupRx.data <= ~setupRx.data; // Released data line shows no stale byte.
        setupRx.done  <= 1'b1;
        setupRx.ok    <= ok;
        setupRx.fwReq <= fw;
        @(posedge ref_clk) setupRx <= '0;
    endtask

    // One IN token or one host ACK for the control endpoint.
    task automatic inEvent(input logic isAck);
        @(posedge ref_clk) inCtl.token <= ~isAck;
        inCtl.ack <= isAck;
        @(posedge ref_clk) inCtl <= '0;
    endtask

    // One status-stage pulse for the control endpoint.
    task automatic stage();
        @(posedge ref_clk) inCtl.statusStage <= 1'b1;
        @(posedge ref_clk) inCtl <= '0;
    endtask

    // Sends n bulk-out bytes counting up from base, then a good end of packet.
    task automatic bulk(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) outRx.valid <= 1'b1;
            outRx.data <= base + 8'(i);
        end
        @(posedge ref_clk) outRx.valid <= 1'b0;
        outRx.data <= ~outRx.data;
        outRx.done <= 1'b1;
        outRx.ok   <= 1'b1;
        @(posedge ref_clk) outRx <= '0;
    endtask
endmodule

/* tb_usb_endpoint_data_buffers.sv */
// Self-checking testbench for the endpoint data buffers.
`timescale 1ns/10ps
`include "ued_defines.svh"
module tb_usb_endpoint_data_buffers
    import ued_pkg::*;
;
    logic          ref_clk, sys_rst, avsRead, avsWrite, sieBusReset;
    logic [15:0]   avsAddress;
    logic [3:0]    avsByteEnable;
    logic [31:0]   avsWriteData, avsReadData;
    logic          avsWaitRequest, bulkOutStall, endpointEventIrq;
    logic [7:0]    q;
    int            nMismatch, cmpCount;
    ued_setup_rx_t setupRx;
    ued_in_ctl_t   inCtl;
    ued_out_rx_t   outRx;
    ued_tx_t       inTx;

    ued_buffers DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsByteEnable(avsByteEnable),
        .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .sieBusReset(sieBusReset), .setupRx(setupRx),
        .inCtl(inCtl), .outRx(outRx), .inTx(inTx), .bulkOutStall(bulkOutStall),
        .endpointEventIrq(endpointEventIrq));
    ued_sie_model sie (.ref_clk(ref_clk), .setupRx(setupRx), .inCtl(inCtl), .outRx(outRx));

    // Clock at 125 MHz.
    always #4 ref_clk = ~ref_clk;

    // Counts a comparison and reports a difference.
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmpCount++;
        if (s !== e) begin
            nMismatch++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One Avalon access held until waitrequest is sampled low; read byte lands in q.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk) avsAddress <= a;
        avsWriteData <= {24'h0, d};
        avsWrite <= wr;
        avsRead <= ~wr;
        do begin
            @(posedge ref_clk) n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        q = avsReadData[7:0];
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (n >= 50) begin
            nMismatch++;
            end_of_test();
        end
    endtask

    // Reads cnt setup bytes; the pointer starts at from and wraps after eight.
    task automatic rd(input int from, input int cnt, input logic [7:0] base);
        for (int k = 0; k < cnt; k++) begin
            bus(1'b0, `UED_IDX_SETUP_CAPTURE, 8'h00);
            chk(q, base + 8'((from + k) % 8));
        end
    endtask

    // Setup capture: order, wrap, overwrite mid-read, short and bad transactions.
    task automatic t_setup();
        sie.setup(8, 1'b1, 1'b1, 8'h10);
        #1 chk(endpointEventIrq, 8'h01);
        bus(1'b1, `UED_IDX_SETUP_CAPTURE, 8'hff);
        rd(0, 16, 8'h10);
        bus(1'b0, `UED_IDX_STATUS, 8'h00);
        chk(q, 8'h03);
        rd(0, 3, 8'h10);
        sie.setup(8, 1'b1, 1'b0, 8'h20);
        rd(3, 5, 8'h20);
        sie.setup(5, 1'b1, 1'b0, 8'h40);
        rd(0, 3, 8'h20);
        @(posedge ref_clk) sieBusReset <= 1'b1;
        @(posedge ref_clk) sieBusReset <= 1'b0;
        rd(3, 5, 8'h20);
        sie.setup(8, 1'b0, 1'b1, 8'h60);
        #1 chk(endpointEventIrq, 8'h00);
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, `UED_IDX_SETUP_CAPTURE, 8'h00);
            chk(q, 8'h00);
        end
        $display("setup capture test done");
    endtask

    // Control IN: NAK, byte stream, self-clearing ready, zero-length packet, flush.
    task automatic t_ctl_in();
        bus(1'b1, `UED_IDX_CTL_IN_WRITE, 8'ha0);
        bus(1'b1, `UED_IDX_CTL_IN_WRITE, 8'ha1);
        bus(1'b0, `UED_IDX_CTL_IN_WRITE, 8'h00);
        chk(q, 8'h00);
        sie.inEvent(1'b0);
        #1 chk(inTx.nak, 8'h01);
        bus(1'b1, `UED_IDX_CONTROL, 8'h03);
        sie.inEvent(1'b0);
        @(posedge ref_clk) #1 chk(inTx.data, 8'ha0);
        @(posedge ref_clk) #1 chk(inTx.data, 8'ha1);
        chk(8'(inTx.last), 8'h01);
        sie.inEvent(1'b1);
        bus(1'b0, `UED_IDX_CONTROL, 8'h00);
        chk(q, 8'h00);
        bus(1'b1, `UED_IDX_CONTROL, 8'h03);
        sie.inEvent(1'b0);
        #1 chk(inTx.zlp, 8'h01);
        sie.inEvent(1'b1);
        bus(1'b1, `UED_IDX_CTL_IN_WRITE, 8'ha2);
        bus(1'b1, `UED_IDX_CONTROL, 8'h01);
        sie.inEvent(1'b0);
        sie.stage();
        bus(1'b0, `UED_IDX_STATUS, 8'h00);
        chk(q & 8'h10, 8'h00);
        bus(1'b1, `UED_IDX_CTL_IN_WRITE, 8'ha2);
        bus(1'b1, `UED_IDX_CONTROL, 8'h01);
        sie.setup(8, 1'b1, 1'b0, 8'h30);
        bus(1'b0, `UED_IDX_STATUS, 8'h00);
        chk(q & 8'h10, 8'h00);
        $display("control IN test done");
    endtask

    // Bulk-out: swap with length, in-order reads, decrement, read past the count.
    task automatic t_bulk();
        sie.bulk(4, 8'hc0);
        #1 chk(endpointEventIrq, 8'h01);
        bus(1'b0, `UED_IDX_BULK_OUT_LENGTH, 8'h00);
        chk(q, 8'h04);
        for (int k = 0; k < 5; k++) begin
            bus(1'b0, `UED_IDX_BULK_OUT_DATA, 8'h00);
            chk(q, 8'hc0 + 8'(k % 4));
            if (k == 3) bus(1'b0, `UED_IDX_BULK_OUT_LENGTH, 8'h00);
            if (k == 3) chk(q, 8'h00);
        end
        bus(1'b0, `UED_IDX_STATUS, 8'h00);
        chk(q & 8'h04, 8'h04);
        $display("bulk-out test done");
    endtask

    // Reset for 20 cycles, then the scenarios.
    initial begin
        {ref_clk, avsRead, avsWrite, sieBusReset} = '0;
        {avsAddress, avsWriteData} = '0;
        avsByteEnable = 4'hf;
        sys_rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_setup();
        t_ctl_in();
        t_bulk();
        end_of_test();
    end
endmodule
